// *** hdl/jtp_dev.sv ***
// Device end: TAP controller, instruction and data chains, and debug pin defaults.
//
// Function
// - TAP advances only on test clock rises
// - Low test reset forces Test-Logic-Reset through a two-stage core-clock synchroniser, with no test clock needed
// - Entering reset state loads IDCODE instruction
// - Five high mode-selects reach reset state
// - Data in sampled on rise into chain
// - Tester changes inputs on falling clock edge
// - Stopped clock keeps state and registers
// - Tester drives half-duty clock, stopped low between bursts
// - Unknown instruction codes decode as BYPASS
// - EXTEST and INTEST never capture or update
// - Instruction selects the accessed data chain
// - TAP state picks chain and operation
// - Debug pins default to debug function
// - Pin reassignment needs unlock and commit
// - Debug input pull-ups default enabled
// - Software keeps pull-ups on debug inputs; pull-up writes need no unlock or commit
// - Data out changes on fall, idles inactive
// - Update states copy chain into parallel register; Update-DR only under SAMPLE
// - Power-on reset also forces reset state
// - Instruction chain is four bits wide
`timescale 1ns/1ps
module jtp_dev
  import jtp_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_ce,
  jtp_link_if.dev           link,
  input  wire logic [4:0]   i_alt_function_select_bit_wdata,
  input  wire logic         i_alt_function_select_bit_we,
  input  wire logic [31:0]  i_lock_wdata,
  input  wire logic         i_lock_we,
  input  wire logic [4:0]   i_commit_wdata,
  input  wire logic         i_commit_we,
  input  wire logic [4:0]   i_pur_wdata,
  input  wire logic         i_pur_we,
  input  wire logic [BS_W-1:0] i_bs_pins,
  output logic [4:0]        o_port_alt_function_select,
  output logic [4:0]        o_pull_up_en,
  output logic [4:0]        o_pull_down_en,
  output logic [BS_W-1:0]   o_bs_update,
  output logic [IR_W-1:0]   o_instr,
  output logic [3:0]        o_tap_state
);

  // Whole state of the device end.
  typedef struct packed {
    logic [1:0]      tck_sy;
    logic [1:0]      tms_sy;
    logic [1:0]      tdi_sy;
    logic [1:0]      trst_sy;
    logic            tck_d;
    jtp_state_t      st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [ID_W-1:0] dr_sh;
    logic [BS_W-1:0] bs_upd;
    logic            tdo;
    logic            tdo_oe;
    logic            unlocked;
    logic [4:0]      commit;
    logic [4:0]      alt_function_select_bit;
    logic [4:0]      pur;
  } jtp_dev_t;

  jtp_dev_t s_r;
  jtp_dev_t s_nxt;

  logic rise;
  logic fall;
  logic dr_len_bs;
  logic dr_len_by;

  // Edges are found on the second synchroniser stage against a third copy.
  assign rise = s_r.tck_sy[1] & ~s_r.tck_d;
  assign fall = ~s_r.tck_sy[1] & s_r.tck_d;

  // Chain selection from the held instruction; unknown codes act as bypass.
  always_comb
  begin
    dr_len_bs = (s_r.ir == INS_SAMPLE) || (s_r.ir == INS_EXTEST) ||
                (s_r.ir == INS_INTEST);
    dr_len_by = !dr_len_bs && (s_r.ir != INS_IDCODE);
  end

  // Next-state process covering the TAP, the chains and the pin controls.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tck_sy  = {s_r.tck_sy[0], link.tck};
    s_nxt.tms_sy  = {s_r.tms_sy[0], link.tms};
    s_nxt.tdi_sy  = {s_r.tdi_sy[0], link.tdi};
    s_nxt.trst_sy = {s_r.trst_sy[0], link.trst_b};
    s_nxt.tck_d   = s_r.tck_sy[1];
    if (!s_r.trst_sy[1])
    begin
      // Held in reset while the test reset is low, whatever the clock does.
      s_nxt.st     = ST_RESET;
      s_nxt.ir     = INS_IDCODE;
      s_nxt.tdo_oe = 1'b0;
    end
    else if (rise)
    begin
      // Work on the current state, then step the graph. No rise, no change.
      case (s_r.st)
        ST_CAP_IR: s_nxt.ir_sh = IR_CAPTURE;
        ST_SH_IR:  s_nxt.ir_sh = {s_r.tdi_sy[1], s_r.ir_sh[IR_W-1:1]};
        ST_UPD_IR: s_nxt.ir    = s_r.ir_sh;
        ST_CAP_DR:
        begin
          // Bypass captures zero; extest and intest keep the chain as is.
          if (s_r.ir == INS_IDCODE)
            s_nxt.dr_sh = ID_VALUE;
          else if (s_r.ir == INS_SAMPLE)
            s_nxt.dr_sh = {{(ID_W-BS_W){1'b0}}, i_bs_pins};
          else if (dr_len_by)
            s_nxt.dr_sh = '0;
        end
        ST_SH_DR:
        begin
          if (s_r.ir == INS_IDCODE)
            s_nxt.dr_sh = {s_r.tdi_sy[1], s_r.dr_sh[ID_W-1:1]};
          else if (s_r.ir == INS_SAMPLE)
            s_nxt.dr_sh[BS_W-1:0] = {s_r.tdi_sy[1], s_r.dr_sh[BS_W-1:1]};
          else if (dr_len_by)
            s_nxt.dr_sh[0] = s_r.tdi_sy[1];
        end
        ST_UPD_DR:
        begin
          if (s_r.ir == INS_SAMPLE)
            s_nxt.bs_upd = s_r.dr_sh[BS_W-1:0];
        end
        default: s_nxt.dr_sh = s_r.dr_sh;
      endcase
      // Sixteen-state graph; five high samples always end in reset.
      case (s_r.st)
        ST_RESET:  s_nxt.st = s_r.tms_sy[1] ? ST_RESET  : ST_IDLE;
        ST_IDLE:   s_nxt.st = s_r.tms_sy[1] ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: s_nxt.st = s_r.tms_sy[1] ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: s_nxt.st = s_r.tms_sy[1] ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  s_nxt.st = s_r.tms_sy[1] ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: s_nxt.st = s_r.tms_sy[1] ? ST_UPD_DR : ST_PA_DR;
        ST_PA_DR:  s_nxt.st = s_r.tms_sy[1] ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: s_nxt.st = s_r.tms_sy[1] ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: s_nxt.st = s_r.tms_sy[1] ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: s_nxt.st = s_r.tms_sy[1] ? ST_RESET  : ST_CAP_IR;
        ST_CAP_IR: s_nxt.st = s_r.tms_sy[1] ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  s_nxt.st = s_r.tms_sy[1] ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: s_nxt.st = s_r.tms_sy[1] ? ST_UPD_IR : ST_PA_IR;
        ST_PA_IR:  s_nxt.st = s_r.tms_sy[1] ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: s_nxt.st = s_r.tms_sy[1] ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: s_nxt.st = s_r.tms_sy[1] ? ST_SEL_DR : ST_IDLE;
        default:   s_nxt.st = ST_RESET;
      endcase
      if (s_nxt.st == ST_RESET)
        s_nxt.ir = INS_IDCODE;
    end
    else if (fall)
    begin
      // Data out moves only on the fall and floats outside shift states.
      s_nxt.tdo_oe = (s_r.st == ST_SH_DR) || (s_r.st == ST_SH_IR);
      s_nxt.tdo    = (s_r.st == ST_SH_IR) ? s_r.ir_sh[0] : s_r.dr_sh[0];
    end

    // A lock write with the key opens the gate; a wrong key closes it again.
    if (i_lock_we)
      s_nxt.unlocked = (i_lock_wdata == LOCK_KEY);
    if (i_commit_we && s_r.unlocked)
      s_nxt.commit = i_commit_wdata;
    // Only committed bits accept a new function select; protects the debugger.
    if (i_alt_function_select_bit_we)
      s_nxt.alt_function_select_bit = (i_alt_function_select_bit_wdata & s_r.commit) | (s_r.alt_function_select_bit & ~s_r.commit);
    if (i_pur_we)
      s_nxt.pur = i_pur_wdata;
  end

  // State register; the clock enable freezes everything, including synchronisers.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      s_r          <= '0;
      s_r.trst_sy  <= 2'h0;
      s_r.st       <= ST_RESET;
      s_r.ir       <= INS_IDCODE;
      s_r.alt_function_select_bit    <= PIN_ALT_FUNCTION_SELECT_BIT_RST;
      s_r.pur      <= PIN_PUR_RST;
    end
    else if (i_ce)
      s_r <= s_nxt;
  end

  assign link.tdo                   = s_r.tdo;
  assign link.tdo_oe                = s_r.tdo_oe;
  assign o_port_alt_function_select = s_r.alt_function_select_bit;
  assign o_pull_up_en               = s_r.pur;
  assign o_pull_down_en             = PIN_PDR_RST;
  assign o_bs_update                = s_r.bs_upd;
  assign o_instr                    = s_r.ir;
  assign o_tap_state                = s_r.st;

endmodule

// *** hdl/jtp_pkg.sv ***
// Package with the constants and types shared by both ends of the test access port link.
package jtp_pkg;

  // TAP states, Gray coded along the usual walk.
  typedef enum logic [3:0] {
    ST_RESET   = 4'h0,
    ST_IDLE    = 4'h1,
    ST_SEL_DR  = 4'h3,
    ST_CAP_DR  = 4'h2,
    ST_SH_DR   = 4'h6,
    ST_EX1_DR  = 4'h7,
    ST_PA_DR   = 4'h5,
    ST_EX2_DR  = 4'h4,
    ST_UPD_DR  = 4'hC,
    ST_SEL_IR  = 4'hD,
    ST_CAP_IR  = 4'hF,
    ST_SH_IR   = 4'hE,
    ST_EX1_IR  = 4'hA,
    ST_PA_IR   = 4'hB,
    ST_EX2_IR  = 4'h9,
    ST_UPD_IR  = 4'h8
  } jtp_state_t;

  // Instruction chain width and codes.
  localparam int unsigned IR_W = 4;
  localparam logic [IR_W-1:0] INS_EXTEST  = 4'h0;
  localparam logic [IR_W-1:0] INS_INTEST  = 4'h1;
  localparam logic [IR_W-1:0] INS_SAMPLE  = 4'h2;
  localparam logic [IR_W-1:0] INS_IDCODE  = 4'hE;
  localparam logic [IR_W-1:0] INS_BYPASS  = 4'hF;
  // Fixed pattern captured into the instruction chain.
  localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;

  // Data chain widths.
  localparam int unsigned ID_W = 32;
  localparam int unsigned BS_W = 8;
  // Identity word; the value is arbitrary.
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_0001;

  // Pin reset defaults: debug function selected, pull-ups on, pull-downs off.
  localparam logic [4:0] PIN_ALT_FUNCTION_SELECT_BIT_RST = 5'h1F;
  localparam logic [4:0] PIN_PUR_RST   = 5'h1F;
  localparam logic [4:0] PIN_PDR_RST   = 5'h00;
  // Key that opens the commit lock; the value is arbitrary.
  localparam logic [31:0] LOCK_KEY = 32'h4C4F_434B;

  // Host clock divider: half period of the generated test clock in core cycles.
  localparam int unsigned TCK_HALF     = 6;
  localparam int unsigned DIV_W        = 3;
  localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(TCK_HALF - 1);
  localparam int unsigned CNT_W        = 6;
  // Count of high mode-select edges for a soft reset.
  localparam logic [2:0] SOFT_RST_LEN  = 3'h5;

endpackage

// *** hdl/jtp_link_if.sv ***
// Interface carrying the five test access port wires between tester and device.
`timescale 1ns/1ps
interface jtp_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic trst_b;

  // Device end samples clock, select, data and reset; drives data out.
  modport dev
  (
    input  tck,
    input  tms,
    input  tdi,
    input  trst_b,
    output tdo,
    output tdo_oe
  );

  // Tester end makes the clock and reads the data out.
  modport host
  (
    output tck,
    output tms,
    output tdi,
    output trst_b,
    input  tdo,
    input  tdo_oe
  );
endinterface

// *** hdl/jtp_host.sv ***
// Tester end: makes the test clock and clocks out mode-select and data bits.
`timescale 1ns/1ps
module jtp_host
  import jtp_pkg::*;
(
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_ce,
  jtp_link_if.host              link,
  input  wire logic             i_start,
  input  wire logic [CNT_W-1:0] i_nbits,
  input  wire logic [ID_W-1:0]  i_tms_bits,
  input  wire logic [ID_W-1:0]  i_tdi_bits,
  input  wire logic             i_trst_b,
  output logic                  o_busy,
  output logic                  o_done,
  output logic [ID_W-1:0]       o_tdo_bits
);

  // Host phases.
  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_LOW  = 2'h1,
    HS_HIGH = 2'h3
  } jtp_hst_t;

  // Whole state of the host end.
  typedef struct packed {
    jtp_hst_t         ph;
    logic [DIV_W-1:0] div;
    logic [CNT_W-1:0] left;
    logic [ID_W-1:0]  tms;
    logic [ID_W-1:0]  tdi;
    logic [ID_W-1:0]  cap;
    logic [1:0]       tdo_sy;
    logic             tck;
    logic             tms_o;
    logic             tdi_o;
    logic             trst_b;
    logic             done;
  } jtp_host_t;

  jtp_host_t h_r;
  jtp_host_t h_nxt;

  // Clock divider with half-duty phases; bits change only while the clock is low.
  always_comb
  begin
    h_nxt        = h_r;
    h_nxt.tdo_sy = {h_r.tdo_sy[0], link.tdo};
    h_nxt.trst_b = i_trst_b;
    h_nxt.done   = 1'b0;
    case (h_r.ph)
      HS_IDLE:
      begin
        if (i_start && (i_nbits != '0))
        begin
          h_nxt.ph    = HS_LOW;
          h_nxt.div   = '0;
          h_nxt.left  = i_nbits;
          h_nxt.tms   = i_tms_bits >> 1;
          h_nxt.tdi   = i_tdi_bits >> 1;
          h_nxt.tms_o = i_tms_bits[0];
          h_nxt.tdi_o = i_tdi_bits[0];
        end
      end
      HS_LOW:
      begin
        h_nxt.div = h_r.div + 1'b1;
        if (h_r.div == DIV_TOP)
        begin
          h_nxt.ph  = HS_HIGH;
          h_nxt.div = '0;
          h_nxt.tck = 1'b1;
          // Sample device data on the rise; it moved on the last fall.
          h_nxt.cap = {h_r.tdo_sy[1], h_r.cap[ID_W-1:1]};
        end
      end
      HS_HIGH:
      begin
        h_nxt.div = h_r.div + 1'b1;
        if (h_r.div == DIV_TOP)
        begin
          h_nxt.div   = '0;
          h_nxt.tck   = 1'b0;
          h_nxt.left  = h_r.left - 1'b1;
          h_nxt.tms_o = h_r.tms[0];
          h_nxt.tdi_o = h_r.tdi[0];
          h_nxt.tms   = h_r.tms >> 1;
          h_nxt.tdi   = h_r.tdi >> 1;
          if (h_r.left == CNT_W'(1))
          begin
            h_nxt.ph   = HS_IDLE;
            h_nxt.done = 1'b1;
          end
          else
            h_nxt.ph = HS_LOW;
        end
      end
      default: h_nxt.ph = HS_IDLE;
    endcase
  end

  // State register; the clock stops low between bursts, which the device tolerates.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      h_r        <= '0;
      h_r.ph     <= HS_IDLE;
      h_r.tms_o  <= 1'b1;
      h_r.trst_b <= 1'b0;
    end
    else if (i_ce)
      h_r <= h_nxt;
  end

  assign link.tck    = h_r.tck;
  assign link.tms    = h_r.tms_o;
  assign link.tdi    = h_r.tdi_o;
  assign link.trst_b = h_r.trst_b;
  assign o_busy      = (h_r.ph != HS_IDLE);
  assign o_done      = h_r.done;
  assign o_tdo_bits  = h_r.cap;

endmodule

// *** sim/jtp_link_monitor.sv ***
// Checker for the five test access port wires between the two ends.
`timescale 1ns/1ps
module jtp_link_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic trst_b
);
  logic       tck_q_r;
  logic [2:0] hi_cnt_r;

  // Counts test clock rises with mode-select high, saturating at five.
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tck_q_r  <= 1'b0;
      hi_cnt_r <= 3'h0;
    end
    else
    begin
      tck_q_r <= tck;
      if (tck && !tck_q_r)
        hi_cnt_r <= !tms ? 3'h0 : (hi_cnt_r == 3'h5 ? 3'h5 : hi_cnt_r + 3'h1);
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_high_phase;
    tck [*6] ##1 !tck;
  endsequence
  sequence s_low_phase;
    !tck [*6];
  endsequence

  property p_tck_high;
    $rose(tck) |-> s_high_phase;
  endproperty
  property p_tck_low;
    $fell(tck) |-> s_low_phase;
  endproperty
  property p_in_when_low;
    $changed(tms) || $changed(tdi) |-> !tck;
  endproperty
  property p_tdo_when_low;
    $changed(tdo) && tdo_oe |-> !tck;
  endproperty
  property p_tdo_hold;
    $rose(tck) && tdo_oe |=> $stable(tdo) [*5];
  endproperty
  property p_oe_when_low;
    $changed(tdo_oe) && trst_b && $past(trst_b, 8) |-> !tck;
  endproperty
  property p_oe_trst;
    !trst_b [*6] |-> !tdo_oe;
  endproperty
  property p_soft_reset;
    hi_cnt_r == 3'h5 |-> !tdo_oe;
  endproperty

  a_tck_high: assert property (p_tck_high)
    else $error("test clock high phase has the wrong length");
  a_tck_low: assert property (p_tck_low)
    else $error("test clock low phase is too short");
  a_in_when_low: assert property (p_in_when_low)
    else $error("select or data in changed while test clock high");
  a_tdo_when_low: assert property (p_tdo_when_low)
    else $error("data out changed while test clock high");
  a_tdo_hold: assert property (p_tdo_hold)
    else $error("data out not held through the high phase");
  a_oe_when_low: assert property (p_oe_when_low)
    else $error("data out enable changed while test clock high");
  a_oe_trst: assert property (p_oe_trst)
    else $error("data out still driven during test reset");
  a_soft_reset: assert property (p_soft_reset)
    else $error("data out driven after five high select rises");
endmodule

// *** sim/test_jtag_tap_port.sv ***
// Testbench joining the tester end and the device end across the link.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module test_jtag_tap_port
  import jtp_pkg::*;
;
  logic             i_core_clk = 1'b0;
  logic             i_rst_b    = 1'b0;
  logic             i_start    = 1'b0;
  logic [CNT_W-1:0] i_nbits    = '0;
  logic [ID_W-1:0]  i_tms_bits = '0;
  logic [ID_W-1:0]  i_tdi_bits = '0;
  logic             i_trst_b   = 1'b1;
  logic [BS_W-1:0]  i_bs_pins  = '0;
  logic [31:0]      pin_wd     = '0;
  logic [3:0]       pin_we     = '0;
  logic             o_busy;
  logic             o_done;
  logic [ID_W-1:0]  o_tdo_bits;
  logic [4:0]       o_port_alt_function_select;
  logic [4:0]       o_pull_up_en;
  logic [4:0]       o_pull_down_en;
  logic [BS_W-1:0]  o_bs_update;
  logic [IR_W-1:0]  o_instr;
  logic [3:0]       o_tap_state;
  logic [ID_W-1:0]  q;
  int               n_mismatch   = 0;
  int               total_checks = 0;

  // Core clock, 4 ns period.
  always #2 i_core_clk = ~i_core_clk;

  jtp_link_if jtp_link_if_i ();
  jtp_host jtp_host_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(1'b1),
    .link(jtp_link_if_i), .i_start(i_start), .i_nbits(i_nbits), .i_tms_bits(i_tms_bits),
    .i_tdi_bits(i_tdi_bits), .i_trst_b(i_trst_b), .o_busy(o_busy), .o_done(o_done),
    .o_tdo_bits(o_tdo_bits));
  jtp_dev jtp_dev_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(1'b1),
    .link(jtp_link_if_i), .i_alt_function_select_bit_wdata(pin_wd[4:0]), .i_alt_function_select_bit_we(pin_we[0]),
    .i_lock_wdata(pin_wd), .i_lock_we(pin_we[1]), .i_commit_wdata(pin_wd[4:0]),
    .i_commit_we(pin_we[2]), .i_pur_wdata(pin_wd[4:0]), .i_pur_we(pin_we[3]),
    .i_bs_pins(i_bs_pins), .o_port_alt_function_select(o_port_alt_function_select),
    .o_pull_up_en(o_pull_up_en), .o_pull_down_en(o_pull_down_en),
    .o_bs_update(o_bs_update), .o_instr(o_instr), .o_tap_state(o_tap_state));
  jtp_link_monitor jtp_link_monitor_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .tck(jtp_link_if_i.tck), .tms(jtp_link_if_i.tms), .tdi(jtp_link_if_i.tdi),
    .tdo(jtp_link_if_i.tdo), .tdo_oe(jtp_link_if_i.tdo_oe), .trst_b(jtp_link_if_i.trst_b));

  // One tester sequence of n bits; waits for done under a bound, then lets tdo settle.
  task automatic run(input int n, input logic [ID_W-1:0] tms, input logic [ID_W-1:0] tdi);
    int k;
    @(negedge i_core_clk);
    i_start = 1'b1;
    i_nbits = CNT_W'(n);
    i_tms_bits = tms;
    i_tdi_bits = tdi;
    @(negedge i_core_clk);
    i_start = 1'b0;
    `CHK(o_busy, 1'b1);
    k = 0;
    while (o_done !== 1'b1 && k < n * 12 + 40)
    begin
      @(negedge i_core_clk);
      k++;
    end
    `CHK(o_done, 1'b1);
    `CHK(o_busy, 1'b0);
    repeat (8) @(negedge i_core_clk);
  endtask

  // Idle to idle through the instruction path; the capture pattern comes out first.
  task automatic ir_load(input logic [IR_W-1:0] code, input bit known);
    run(10, 32'h183, {24'h0, code, 4'h0});
    `CHK(o_tdo_bits[29:26], IR_CAPTURE);
    if (known)
      `CHK(o_instr, code);
  endtask

  // Idle to idle through the data path with n shifted bits, at most 27.
  task automatic dr_scan(input int n, input logic [ID_W-1:0] d, output logic [ID_W-1:0] r);
    run(n + 5, (32'h1 << (n + 2)) | (32'h1 << (n + 3)) | 32'h1, d << 3);
    r = (o_tdo_bits >> (30 - n)) & ((32'h1 << n) - 32'h1);
  endtask

  // Pulses one pin control write: 0 select, 1 lock, 2 commit, 3 pull-up.
  task automatic wr(input int sel, input logic [31:0] d);
    @(negedge i_core_clk);
    pin_wd = d;
    pin_we[sel] = 1'b1;
    @(negedge i_core_clk);
    pin_we = '0;
    @(negedge i_core_clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Power-on reset defaults of the TAP and of the pin controls.
  task automatic t_reset_defaults();
    repeat (20) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_core_clk);
    `CHK(o_tap_state, ST_RESET);
    `CHK(o_instr, INS_IDCODE);
    `CHK(o_port_alt_function_select, PIN_ALT_FUNCTION_SELECT_BIT_RST);
    `CHK(o_pull_up_en, 5'h1F);
    `CHK(o_pull_down_en, 5'h00);
  endtask

  // Identity chain read straight out of reset.
  task automatic t_idcode();
    run(1, 32'h0, 32'h0);
    dr_scan(27, 32'h0, q);
    `CHK(q[26:0], ID_VALUE[26:0]);
    `CHK(o_tap_state, ST_IDLE);
  endtask

  // Bypass and an unknown code both give a one-bit path.
  task automatic t_bypass();
    for (int i = 0; i < 2; i++)
    begin
      ir_load(i ? 4'h7 : INS_BYPASS, i == 0);
      dr_scan(8, 32'hA5, q);
      `CHK(q[7:0], 8'h4A);
    end
  endtask

  // Sample captures the pins and updates the parallel register.
  task automatic t_sample();
    i_bs_pins = 8'h3C;
    ir_load(INS_SAMPLE, 1'b1);
    dr_scan(8, 32'hC3, q);
    `CHK(q[7:0], 8'h3C);
    `CHK(o_bs_update, 8'hC3);
  endtask

  // Extest and intest leave the parallel register untouched.
  task automatic t_ext_int();
    for (int i = 0; i < 2; i++)
    begin
      ir_load(i ? INS_INTEST : INS_EXTEST, 1'b1);
      dr_scan(8, 32'h55, q);
      `CHK(o_bs_update, 8'hC3);
    end
  endtask

  // Five high selects from mid-shift land in reset with the default instruction.
  task automatic t_soft_reset();
    ir_load(INS_SAMPLE, 1'b1);
    run(8, 32'hF9, 32'h0);
    `CHK(o_tap_state, ST_RESET);
    `CHK(o_instr, INS_IDCODE);
  endtask

  // A low test reset holds the TAP in reset while the clock runs.
  task automatic t_trst();
    run(1, 32'h0, 32'h0);
    ir_load(INS_SAMPLE, 1'b1);
    i_trst_b = 1'b0;
    run(4, 32'h2, 32'h0);
    `CHK(o_tap_state, ST_RESET);
    `CHK(o_instr, INS_IDCODE);
    i_trst_b = 1'b1;
    repeat (6) @(negedge i_core_clk);
  endtask

  // A long stopped clock keeps state and instruction.
  task automatic t_clock_stop();
    run(1, 32'h0, 32'h0);
    ir_load(INS_SAMPLE, 1'b1);
    repeat (200) @(negedge i_core_clk);
    `CHK(o_tap_state, ST_IDLE);
    `CHK(o_instr, INS_SAMPLE);
  endtask

  // Function select changes only through unlock and commit.
  task automatic t_commit();
    wr(0, 32'h0);
    `CHK(o_port_alt_function_select, 5'h1F);
    wr(1, LOCK_KEY);
    wr(2, 32'h01);
    wr(0, 32'h0);
    `CHK(o_port_alt_function_select, 5'h1E);
    wr(1, 32'h0);
    wr(2, 32'h1F);
    wr(0, 32'h0);
    `CHK(o_port_alt_function_select, 5'h1E);
    wr(3, 32'h0A);
    `CHK(o_pull_up_en, 5'h0A);
  endtask

  // Main sequence; each task is one scenario, judged before the next begins.
  initial
  begin
    t_reset_defaults();
    t_idcode();
    t_bypass();
    t_sample();
    t_ext_int();
    t_soft_reset();
    t_trst();
    t_clock_stop();
    t_commit();
    complete_run();
  end

  // Watchdog: the tests need about 11 us, so a hang is cut at 200 us.
  initial
  begin
    #200000;
    n_mismatch++;
    complete_run();
  end
endmodule
